// [fiop_port.v]
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "fiop_regs.vh"

module fiop_port #(
	parameter NPINS = 4
) (
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite slave.
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Pad side.
	input wire [NPINS-1:0] pad_in,
	output reg [NPINS-1:0] pad_out,
	output reg [NPINS-1:0] pad_oe,
	output reg [NPINS-1:0] pad_slew_limit,
	output reg [NPINS-1:0] pad_ttl_sel,
	output reg [NPINS-1:0] pad_pullup_en,
	output reg [NPINS-1:0] pad_analog_en,
	// Peripheral side.
	input wire [NPINS-1:0] periph_sel,
	input wire [NPINS-1:0] periph_out,
	input wire [NPINS-1:0] periph_oe_n,
	input wire [NPINS-1:0] twi_ctrl,
	input wire [NPINS-1:0] analog_out_en,
	output reg [NPINS-1:0] periph_in
);

	// Register index decode, shared by the write and read paths.
	function [3:0] fiop_decode;
		input [7:0] addr;
		begin
			case (addr)
				`FIOP_OFS_PORT: fiop_decode = `FIOP_IDX_PORT;
				`FIOP_OFS_LAT: fiop_decode = `FIOP_IDX_LAT;
				`FIOP_OFS_DIR: fiop_decode = `FIOP_IDX_DIR;
				`FIOP_OFS_ANA: fiop_decode = `FIOP_IDX_ANA;
				`FIOP_OFS_ODR: fiop_decode = `FIOP_IDX_ODR;
				`FIOP_OFS_SLW: fiop_decode = `FIOP_IDX_SLW;
				`FIOP_OFS_THR: fiop_decode = `FIOP_IDX_THR;
				`FIOP_OFS_WPU: fiop_decode = `FIOP_IDX_WPU;
				`FIOP_OFS_STAT: fiop_decode = `FIOP_IDX_STAT;
				default: fiop_decode = `FIOP_IDX_NONE;
			endcase
		end
	endfunction

	// Per-pin control registers, one bit per pin in each.
	reg [NPINS-1:0] output_latch_bits_r; // Output latch.
	reg [NPINS-1:0] pin_direction_bits_r; // One means input.
	reg [NPINS-1:0] analog_input_select_bits_r; // One means analog input.
	reg [NPINS-1:0] open_drain_select_bits_r; // One means sink only.
	reg [NPINS-1:0] slew_limit_select_bits_r; // One means slow edges.
	reg [NPINS-1:0] input_threshold_select_bits_r; // One means TTL levels.
	reg [NPINS-1:0] weak_pullup_enable_bits_r; // One enables the pull-up.

	// Write channel capture.
	reg aw_held_r; // Write address captured.
	reg w_held_r; // Write data captured.
	reg [7:0] aw_addr_r; // Captured write address.
	reg [31:0] w_data_r; // Captured write data.
	reg [3:0] w_strb_r; // Captured byte strobes.

	wire [NPINS-1:0] pin_sync; // Synchronised pad levels.
	reg [NPINS-1:0] port_pin_data; // Digital readback after analog masking.
	reg [NPINS-1:0] drive_en; // Pin driven by any digital source.
	reg [NPINS-1:0] drive_val; // Value the source wants on the pin.
	reg [NPINS-1:0] od_eff; // Effective open-drain selection.
	reg [NPINS-1:0] pin_owner; // One where the pin select logic owns the pin.
	wire [3:0] wr_idx;
	wire [3:0] rd_idx;
	wire wr_fire;
	reg [31:0] rd_val;
	reg rd_err;
	integer i;

	// Pads cross into the clock domain before any read or merge uses them.
	fiop_sync #(
		.WIDTH(NPINS)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(pad_in),
		.sync_out(pin_sync)
	);

	// Digital input path and output mux, evaluated pin by pin.
	always @* begin
		for (i = 0; i < NPINS; i = i + 1) begin
			// Analog pins read zero on every digital read.
			port_pin_data[i] = pin_sync[i] & ~analog_input_select_bits_r[i];
			pin_owner[i] = periph_sel[i];
			// The latch is the source unless the pin select logic takes over.
			drive_val[i] = pin_owner[i] ? periph_out[i] : output_latch_bits_r[i];
			// Direction gates the driver even on analog pins; analog select is not
			// consulted here, so digital output keeps working.
			if (analog_out_en[i]) begin
				// An analog output owns the pin; the digital driver steps aside.
				drive_en[i] = 1'b0;
			end else if (pin_owner[i]) begin
				drive_en[i] = ~pin_direction_bits_r[i] & ~periph_oe_n[i];
			end else begin
				drive_en[i] = ~pin_direction_bits_r[i];
			end
			// A two-wire peripheral forces open drain on its own pins.
			od_eff[i] = open_drain_select_bits_r[i] | twi_ctrl[i];
		end
	end

	// Pad outputs are registered so the pins see no decode glitches.
	always @(posedge aclk) begin
		if (!aresetn) begin
			pad_out <= {NPINS{1'b0}};
			pad_oe <= {NPINS{1'b0}};
			pad_slew_limit <= `FIOP_RST_SLW;
			pad_ttl_sel <= `FIOP_RST_THR;
			pad_pullup_en <= `FIOP_RST_WPU;
			pad_analog_en <= `FIOP_RST_ANA;
			periph_in <= {NPINS{1'b0}};
		end else begin
			// Open drain drives only the low level; push-pull drives both.
			pad_out <= drive_val & ~od_eff;
			pad_oe <= drive_en & (~od_eff | ~drive_val);
			pad_slew_limit <= slew_limit_select_bits_r;
			// The pad threshold feeds both port reads and the peripheral input.
			pad_ttl_sel <= input_threshold_select_bits_r;
			pad_pullup_en <= weak_pullup_enable_bits_r;
			pad_analog_en <= analog_input_select_bits_r;
			periph_in <= port_pin_data;
		end
	end

	assign wr_idx = fiop_decode(aw_addr_r);
	assign rd_idx = fiop_decode(s_axi_araddr);
	assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;

	// Address and data are taken in either order and held until both exist.
	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;

	// Write channel capture and response.
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FIOP_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Unmapped or read-only offsets answer with a slave error.
				if (wr_idx == `FIOP_IDX_NONE || wr_idx == `FIOP_IDX_STAT) begin
					s_axi_bresp <= `FIOP_RESP_SLVERR;
				end else begin
					s_axi_bresp <= `FIOP_RESP_OKAY;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control register file; only byte lane zero holds data.
	always @(posedge aclk) begin
		if (!aresetn) begin
			output_latch_bits_r <= `FIOP_RST_LAT;
			pin_direction_bits_r <= `FIOP_RST_DIR;
			analog_input_select_bits_r <= `FIOP_RST_ANA;
			open_drain_select_bits_r <= `FIOP_RST_ODR;
			slew_limit_select_bits_r <= `FIOP_RST_SLW;
			input_threshold_select_bits_r <= `FIOP_RST_THR;
			weak_pullup_enable_bits_r <= `FIOP_RST_WPU;
		end else if (wr_fire) begin
			case (wr_idx)
				`FIOP_IDX_PORT: begin
					// The pins are sampled first and the written lane is merged on
					// top; a write without lane zero copies the pins into the latch,
					// which is the usual hazard on pins held by an outside load.
					if (w_strb_r[0]) begin
						output_latch_bits_r <= w_data_r[NPINS-1:0];
					end else begin
						output_latch_bits_r <= port_pin_data;
					end
				end
				`FIOP_IDX_LAT: begin
					if (w_strb_r[0]) begin
						output_latch_bits_r <= w_data_r[NPINS-1:0];
					end
				end
				`FIOP_IDX_DIR: begin
					if (w_strb_r[0]) begin
						pin_direction_bits_r <= w_data_r[NPINS-1:0];
					end
				end
				`FIOP_IDX_ANA: begin
					if (w_strb_r[0]) begin
						analog_input_select_bits_r <= w_data_r[NPINS-1:0];
					end
				end
				`FIOP_IDX_ODR: begin
					if (w_strb_r[0]) begin
						open_drain_select_bits_r <= w_data_r[NPINS-1:0];
					end
				end
				`FIOP_IDX_SLW: begin
					if (w_strb_r[0]) begin
						slew_limit_select_bits_r <= w_data_r[NPINS-1:0];
					end
				end
				`FIOP_IDX_THR: begin
					// Software must keep peripherals idle while changing this,
					// since the pad can glitch as the threshold moves.
					if (w_strb_r[0]) begin
						input_threshold_select_bits_r <= w_data_r[NPINS-1:0];
					end
				end
				`FIOP_IDX_WPU: begin
					if (w_strb_r[0]) begin
						weak_pullup_enable_bits_r <= w_data_r[NPINS-1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Read data mux; upper bits read as zero.
	always @* begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		case (rd_idx)
			`FIOP_IDX_PORT: rd_val[NPINS-1:0] = port_pin_data;
			`FIOP_IDX_LAT: rd_val[NPINS-1:0] = output_latch_bits_r;
			`FIOP_IDX_DIR: rd_val[NPINS-1:0] = pin_direction_bits_r;
			`FIOP_IDX_ANA: rd_val[NPINS-1:0] = analog_input_select_bits_r;
			`FIOP_IDX_ODR: rd_val[NPINS-1:0] = open_drain_select_bits_r;
			`FIOP_IDX_SLW: rd_val[NPINS-1:0] = slew_limit_select_bits_r;
			`FIOP_IDX_THR: rd_val[NPINS-1:0] = input_threshold_select_bits_r;
			`FIOP_IDX_WPU: rd_val[NPINS-1:0] = weak_pullup_enable_bits_r;
			// Status shows which pins the digital pad driver enables right now.
			`FIOP_IDX_STAT: rd_val[NPINS-1:0] = pad_oe;
			default: rd_err = 1'b1;
		endcase
	end

	// One read at a time; a new address is taken only after the answer left.
	assign s_axi_arready = ~s_axi_rvalid;

	// Read response register.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `FIOP_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_err ? `FIOP_RESP_SLVERR : `FIOP_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// [fiop_regs.vh]
`ifndef FIOP_REGS_VH
`define FIOP_REGS_VH

// Register byte offsets on the AXI4-Lite bus.
`define FIOP_OFS_PORT 8'h00
`define FIOP_OFS_LAT 8'h04
`define FIOP_OFS_DIR 8'h08
`define FIOP_OFS_ANA 8'h0C
`define FIOP_OFS_ODR 8'h10
`define FIOP_OFS_SLW 8'h14
`define FIOP_OFS_THR 8'h18
`define FIOP_OFS_WPU 8'h1C
`define FIOP_OFS_STAT 8'h20

// Decoded register indices.
`define FIOP_IDX_PORT 4'h0
`define FIOP_IDX_LAT 4'h1
`define FIOP_IDX_DIR 4'h2
`define FIOP_IDX_ANA 4'h3
`define FIOP_IDX_ODR 4'h4
`define FIOP_IDX_SLW 4'h5
`define FIOP_IDX_THR 4'h6
`define FIOP_IDX_WPU 4'h7
`define FIOP_IDX_STAT 4'h8
`define FIOP_IDX_NONE 4'hF

// Reset values of the four-bit control fields.
`define FIOP_RST_LAT 4'h0
`define FIOP_RST_DIR 4'hF
`define FIOP_RST_ANA 4'hF
`define FIOP_RST_ODR 4'h0
`define FIOP_RST_SLW 4'hF
`define FIOP_RST_THR 4'h0
`define FIOP_RST_WPU 4'h0

// Bus response codes.
`define FIOP_RESP_OKAY 2'b00
`define FIOP_RESP_SLVERR 2'b10

// Synchroniser depth.
`define FIOP_SYNC_STAGES 2

`endif

// [fiop_sync.v]
`timescale 1ns/1ps

// Two-stage synchroniser for pad inputs; only the second stage is read outside.
module fiop_sync #(
	parameter WIDTH = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_r; // First stage, may go metastable.
	reg [WIDTH-1:0] sync_r; // Second stage, safe to use.

	// Both stages clear on reset so reads start from a known zero.
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= {WIDTH{1'b0}};
			sync_r <= {WIDTH{1'b0}};
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;

endmodule

// [fiop_pin_model.sv]
`timescale 1ns/1ps
// Board side of the pads: the block, an outside driver, a pull-up or nothing.
module fiop_pin_model (
	input wire aclk,
	input wire [3:0] pad_out,
	input wire [3:0] pad_oe,
	input wire [3:0] pad_pullup_en,
	input wire [3:0] ext_en,
	input wire [3:0] ext_val,
	output wire [3:0] pad_in
);
	// A floating pad flips each cycle, so a stale level never passes for a drive.
	logic [3:0] float_r = 4'h5;
	always @(posedge aclk) float_r <= ~float_r;
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
		| (~pad_oe & ~ext_en & (pad_pullup_en | float_r));
endmodule

// [fiop_port_chk.sv]
`timescale 1ns/1ps
// Watches the port block from its own pins only.
module fiop_port_chk (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire [3:0] pad_in,
	input wire [3:0] pad_out,
	input wire [3:0] pad_oe,
	input wire [3:0] pad_slew_limit,
	input wire [3:0] pad_analog_en,
	input wire [3:0] twi_ctrl,
	input wire [3:0] analog_out_en,
	input wire [3:0] periph_in
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rst_vals; $rose(aresetn) |-> pad_analog_en == 4'hF && pad_oe == 4'h0; endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("pad reset state wrong");
	property p_ana_mask; (periph_in & pad_analog_en) == 4'h0; endproperty
	a_ana_mask: assert property (p_ana_mask) else $error("analog pin reads one");
	// Three quiet cycles of a pin must reach the readback through three flops.
	property p_sync; $past(aresetn, 3) && $past(aresetn, 2) && $past(aresetn)
		&& pad_analog_en == 4'h0 && $stable(pad_in) && pad_in == $past(pad_in, 2)
		&& pad_in == $past(pad_in, 3) |-> periph_in == pad_in; endproperty
	a_sync: assert property (p_sync) else $error("pin readback lags");
	property p_twi_od; (pad_oe & pad_out & $past(twi_ctrl)) == 4'h0; endproperty
	a_twi_od: assert property (p_twi_od) else $error("two-wire pin drives high");
	property p_aout; (pad_oe & $past(analog_out_en)) == 4'h0; endproperty
	a_aout: assert property (p_aout) else $error("digital drive on analog output");
	property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
	property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata[3:0] != 4'h0);
	c_twi: cover property (twi_ctrl != 4'h0 && pad_oe != 4'h0);
endmodule
bind fiop_port fiop_port_chk u_chk (.*);

// [fiop_port_bench.sv]
`timescale 1ns/1ps
`include "fiop_regs.vh"
// Drives the port block through its register bus and its pads.
module fiop_port_bench;
	localparam logic [1:0] rok = `FIOP_RESP_OKAY;
	localparam logic [1:0] rerr = `FIOP_RESP_SLVERR;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0, psel = '0, pval = '0, poe_n = 4'hF, twi = '0, aout = '0;
	logic [3:0] ext_en = '0, ext_val = '0;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [3:0] pin, pout, poe, pslw, pttl, ppu, pana, pdin;
	int err_total = 0, check_count = 0;
	always #50 aclk = ~aclk;
	fiop_port dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pad_in(pin), .pad_out(pout), .pad_oe(poe), .pad_slew_limit(pslw), .pad_ttl_sel(pttl),
		.pad_pullup_en(ppu), .pad_analog_en(pana), .periph_sel(psel), .periph_out(pval),
		.periph_oe_n(poe_n), .twi_ctrl(twi), .analog_out_en(aout), .periph_in(pdin));
	fiop_pin_model pins (.aclk(aclk), .pad_out(pout), .pad_oe(poe), .pad_pullup_en(ppu),
		.ext_en(ext_en), .ext_val(ext_val), .pad_in(pin));
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Pads follow a commit by one edge and pins need two; stop mid-cycle to sample.
	task settle;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
	endtask
	// Readies are sampled mid-cycle so the release at the next edge never races them.
	task wr(input [7:0] a, input [3:0] d, input [3:0] s, input [1:0] er);
		logic aw_ok, w_ok, b_ok;
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {28'h000_0000, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_ok = 1'b0;
		for (int n = 0; n < 40 && !b_ok; n++) begin
			@(negedge aclk);
			aw_ok = awvalid & awready;
			w_ok = wvalid & wready;
			b_ok = bvalid & bready;
			r = bresp;
			@(posedge aclk);
			if (aw_ok) awvalid <= 1'b0;
			if (w_ok) wvalid <= 1'b0;
			if (b_ok) bready <= 1'b0;
		end
		if (!b_ok) begin
			$display("[ERR] bvalid expected 1 seen 0");
			err_total++;
			give_verdict;
		end else begin
			chk("bresp", er, r);
		end
	endtask
	task rd(input [7:0] a, input [3:0] d, input [1:0] er);
		logic ar_ok, r_ok;
		logic [31:0] v;
		logic [1:0] r;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r_ok = 1'b0;
		for (int n = 0; n < 40 && !r_ok; n++) begin
			@(negedge aclk);
			ar_ok = arvalid & arready;
			r_ok = rvalid & rready;
			v = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar_ok) arvalid <= 1'b0;
			if (r_ok) rready <= 1'b0;
		end
		if (!r_ok) begin
			$display("[ERR] rvalid expected 1 seen 0");
			err_total++;
			give_verdict;
		end else begin
			chk("rdata", {28'h000_0000, d}, v);
			chk("rresp", er, r);
		end
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`FIOP_OFS_LAT, 4'h0, rok);
		rd(`FIOP_OFS_DIR, 4'hF, rok);
		rd(`FIOP_OFS_ANA, 4'hF, rok);
		rd(`FIOP_OFS_ODR, 4'h0, rok);
		rd(`FIOP_OFS_SLW, 4'hF, rok);
		rd(`FIOP_OFS_THR, 4'h0, rok);
		rd(`FIOP_OFS_WPU, 4'h0, rok);
		rd(8'h24, 4'h0, rerr);
		$display("test reset done");
		wr(`FIOP_OFS_WPU, 4'hF, 4'h1, rok);
		settle;
		rd(`FIOP_OFS_PORT, 4'h0, rok);
		wr(`FIOP_OFS_ANA, 4'h0, 4'h1, rok);
		settle;
		rd(`FIOP_OFS_PORT, 4'hF, rok);
		$display("test analog done");
		wr(`FIOP_OFS_LAT, 4'h5, 4'h1, rok);
		wr(`FIOP_OFS_DIR, 4'h0, 4'h1, rok);
		settle;
		chk("pad_out", 4'h5, pout);
		chk("pad_oe", 4'hF, poe);
		wr(`FIOP_OFS_PORT, 4'hA, 4'h1, rok);
		rd(`FIOP_OFS_LAT, 4'hA, rok);
		wr(`FIOP_OFS_ANA, 4'hF, 4'h1, rok);
		settle;
		chk("pad_oe", 4'hF, poe);
		chk("pad_out", 4'hA, pout);
		rd(`FIOP_OFS_PORT, 4'h0, rok);
		wr(`FIOP_OFS_ANA, 4'h0, 4'h1, rok);
		wr(`FIOP_OFS_DIR, 4'hF, 4'h1, rok);
		ext_en <= 4'hF;
		ext_val <= 4'h9;
		settle;
		wr(`FIOP_OFS_PORT, 4'h0, 4'h0, rok);
		rd(`FIOP_OFS_LAT, 4'h9, rok);
		ext_en <= 4'h0;
		$display("test output done");
		wr(`FIOP_OFS_DIR, 4'h0, 4'h1, rok);
		wr(`FIOP_OFS_ODR, 4'hF, 4'h1, rok);
		settle;
		chk("pad_out", 4'h0, pout);
		chk("pad_oe", 4'h6, poe);
		rd(`FIOP_OFS_PORT, 4'h9, rok);
		wr(`FIOP_OFS_ODR, 4'h0, 4'h1, rok);
		twi <= 4'hF;
		settle;
		chk("pad_oe", 4'h6, poe);
		wr(`FIOP_OFS_SLW, 4'h0, 4'h1, rok);
		twi <= 4'h0;
		wr(`FIOP_OFS_THR, 4'hF, 4'h1, rok);
		wr(`FIOP_OFS_WPU, 4'h6, 4'h1, rok);
		psel <= 4'hF;
		pval <= 4'h3;
		poe_n <= 4'h0;
		settle;
		chk("pad_slew_limit", 4'h0, pslw);
		chk("pad_ttl_sel", 4'hF, pttl);
		chk("pad_pullup_en", 4'h6, ppu);
		chk("pad_out", 4'h3, pout);
		wr(`FIOP_OFS_STAT, 4'h0, 4'h1, rerr);
		aout <= 4'h1;
		settle;
		chk("pad_oe", 4'hE, poe);
		rd(`FIOP_OFS_STAT, 4'hE, rok);
		$display("test select done");
		give_verdict;
	end
endmodule
